/* rtl/asr_fifo.sv */
// Result FIFO between the conversion core and the serial readout
module asr_fifo
  import asr_pkg::*;
#(
  parameter int W = 23,
  parameter int D = 32
)
(
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  // Fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // Drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  localparam int AW = $clog2(D);

  typedef struct packed
  {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          rdy;
  } asr_fifo_t;

  asr_fifo_t  s;
  asr_fifo_t  next_s;
  logic [W-1:0] mem [D];
  logic       wr_en;
  logic       rd_en;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes; ready is registered so the core sees a clean level
  assign wr_en   = i_valid & s.rdy;
  assign rd_en   = o_valid & i_ready;
  assign o_ready = s.rdy;
  assign o_valid = (s.cnt != '0);
  assign o_data  = mem[s.rd];

  // Pointer and count update
  always_comb
  begin
    next_s = s;
    if (wr_en)
      next_s.wr = s.wr + 1'b1;
    if (rd_en)
      next_s.rd = s.rd + 1'b1;
    if (wr_en && !rd_en)
      next_s.cnt = s.cnt + 1'b1;
    else if (rd_en && !wr_en)
      next_s.cnt = s.cnt - 1'b1;
    next_s.rdy = (next_s.cnt != (AW+1)'(D));
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      s <= '{rdy: 1'b1, default: '0};
    else
      s <= next_s;
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge i_ref_clk)
  begin
    if (wr_en)
      mem[s.wr] <= i_data;
  end

endmodule

/* rtl/asr_pkg.sv */
// Shared constants, types and reset values of the serial result readout
// How it works
// - Chip select fall picks clock mode from pin
// - Data pin released while chip select high
// - Data pin shows active-low done flag
// - Finish with chip select high enters sleep
// - External mode: result frozen until first rise
// - External 24th fall starts conversion, data high
// - External chip select rise aborts, restarts conversion
// - Clock mode also picked at power-on end
// - Done flag fall loads static shift register
// - Two-wire external: 24th fall drives data high
// - Float or high clock pin gives internal mode
// - Internal mode: chip select low drives clock low
// - Early chip select rise returns to sleep
// - Internal first rise after status test delay
// - Internal: 24 rises, then data, clock high
// - Internal chip select rise aborts, restarts conversion
// - Clock pin low disables its pull-up
// - Status pulse end re-enables clock pull-up
// - Data bits change on falling clock edges
// - Result sent most significant bit first
// - Internal clock is conversion clock over eight
// - Abort only after first clock rise in data output state; earlier rise returns to sleep
package asr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing at the 100 MHz reference clock
  localparam int CLK_NS = 10;
  localparam int POR_NS = 1000000;
  localparam int POR_CYC = POR_NS / CLK_NS;
  localparam int TEST_NS = 23000;
  localparam int TEST_CYC = (TEST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] TEST_LAST = 12'(TEST_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Readout framing
  localparam int RES_W = 23;
  localparam int FIFO_D = 32;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [2:0] DIV_RISE = 3'h3;
  localparam logic [2:0] DIV_FALL = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0]
  {
    ST_POR   = 3'b000,
    ST_CONV  = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAIT  = 3'b011,
    ST_DATA  = 3'b100
  } asr_state_e_t;

  typedef struct packed
  {
    logic sck;
    logic sck_oe;
    logic sck_pull;
    logic sdo;
    logic sdo_oe;
  } asr_pins_t;

  typedef struct packed
  {
    asr_state_e_t st;
    logic         ext;
    logic [23:0]  sr;
    logic [4:0]   bits;
    logic [4:0]   falls;
    logic [2:0]   div;
    logic [11:0]  tmr;
    logic [16:0]  por;
    logic         start;
    asr_pins_t    pin;
    logic         cs1;
    logic         cs2;
    logic         cs3;
    logic         ck1;
    logic         ck2;
    logic         ck3;
  } asr_core_t;

  // Pull-up on and pins idle high at reset
  localparam asr_core_t CORE_RST = '{st: ST_POR, pin: 5'b00100, cs1: 1'b1, cs2: 1'b1, cs3: 1'b1,
                                     ck1: 1'b1, ck2: 1'b1, ck3: 1'b1, default: '0};

endpackage

/* rtl/asr_readout.sv */
// Serial result readout with clock mode selection and done signalling
module asr_readout
  import asr_pkg::*;
#(
  parameter int P_POR_CYCLES = POR_CYC
)
(
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  // Serial pins
  input  wire logic             i_cs_n,
  input  wire logic             i_sck,
  output asr_pins_t             o_pins,
  // Conversion core
  input  wire logic             i_res_valid,
  input  wire logic [RES_W-1:0] i_res_data,
  output logic                  o_res_ready,
  output logic                  o_conv_start
);

  asr_core_t        s;
  asr_core_t        next_s;
  logic             fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic             pop;
  logic             cs_fall;
  logic             cs_rise;
  logic             ck_fall;
  logic             ck_rise;
  logic             mode;

  ////////////////////////////////////////////////////////////////////////////
  // Result buffer; a full buffer stalls the core through o_res_ready
  asr_fifo #(.W(RES_W), .D(FIFO_D)) u_fifo
  (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_valid   (i_res_valid),
    .i_data    (i_res_data),
    .o_ready   (o_res_ready),
    .o_valid   (fifo_valid),
    .o_data    (fifo_data),
    .i_ready   (pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edges seen only past the second synchroniser stage
  assign cs_fall = s.cs3 & ~s.cs2;
  assign cs_rise = ~s.cs3 & s.cs2;
  assign ck_fall = s.ck3 & ~s.ck2;
  assign ck_rise = ~s.ck3 & s.ck2;
  // Mode in force this cycle, including a choice made right now
  assign mode    = (cs_fall && s.st != ST_POR) ? ~s.ck2 : s.ext;

  assign o_pins       = s.pin;
  assign o_conv_start = s.start;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s = s;
    pop = 1'b0;
    next_s.start = 1'b0;
    // Two-stage synchronisers
    next_s.cs1 = i_cs_n;
    next_s.cs2 = s.cs1;
    next_s.cs3 = s.cs2;
    next_s.ck1 = i_sck;
    next_s.ck2 = s.ck1;
    next_s.ck3 = s.ck2;
    // Shared data pin is driven only while selected
    next_s.pin.sdo_oe = ~s.cs2;
    // Pull-up drops when the pin falls and returns once it is high again
    if (s.ck2)
      next_s.pin.sck_pull = 1'b1;
    else if (ck_fall)
      next_s.pin.sck_pull = 1'b0;
    if (cs_fall && s.st != ST_POR)
      next_s.ext = ~s.ck2;
    // External mode never drives the clock pin
    if (cs_fall && mode)
      next_s.pin.sck_oe = 1'b0;
    if (cs_rise && !s.ext)
      next_s.pin.sck_oe = 1'b0;
    unique case (s.st)
      ST_POR:
      begin
        if (s.por == 17'(P_POR_CYCLES - 1))
        begin
          next_s.ext = ~s.ck2;
          next_s.st = ST_CONV;
          next_s.start = 1'b1;
          next_s.pin.sdo = 1'b1;
        end
        else
          next_s.por = s.por + 17'h1;
      end
      ST_CONV:
      begin
        next_s.pin.sdo = 1'b1;
        if (cs_fall && !mode)
        begin
          next_s.pin.sck = 1'b0;
          next_s.pin.sck_oe = 1'b1;
        end
        if (fifo_valid)
        begin
          // Done flag falls and the word is frozen in one step
          pop = 1'b1;
          next_s.sr = {1'b0, fifo_data};
          next_s.pin.sdo = 1'b0;
          if (s.cs2)
            next_s.st = ST_SLEEP;
          else if (mode)
          begin
            next_s.st = ST_DATA;
            next_s.bits = '0;
            next_s.falls = '0;
          end
          else
          begin
            next_s.st = ST_WAIT;
            next_s.tmr = '0;
            next_s.pin.sck = 1'b0;
            next_s.pin.sck_oe = 1'b1;
          end
        end
      end
      ST_SLEEP:
      begin
        next_s.pin.sdo = 1'b0;
        if (cs_fall && mode)
        begin
          next_s.st = ST_DATA;
          next_s.bits = '0;
          next_s.falls = '0;
        end
        else if (cs_fall)
        begin
          next_s.st = ST_WAIT;
          next_s.tmr = '0;
          next_s.pin.sck = 1'b0;
          next_s.pin.sck_oe = 1'b1;
        end
      end
      ST_WAIT:
      begin
        next_s.pin.sdo = 1'b0;
        if (cs_rise)
        begin
          // Status pulse over: result kept, pull-up restored
          next_s.st = ST_SLEEP;
          next_s.pin.sck_pull = 1'b1;
        end
        else if (s.tmr == TEST_LAST)
        begin
          next_s.st = ST_DATA;
          next_s.bits = '0;
          next_s.div = '0;
        end
        else
          next_s.tmr = s.tmr + 12'h1;
      end
      ST_DATA:
      begin
        next_s.pin.sdo = s.sr[23];
        if (cs_rise)
        begin
          if (s.bits == '0)
            next_s.st = ST_SLEEP;
          else
          begin
            next_s.st = ST_CONV;
            next_s.start = 1'b1;
            next_s.pin.sdo = 1'b1;
          end
        end
        else if (s.ext)
        begin
          // Register stays frozen until the first rise
          if (ck_rise)
            next_s.bits = s.bits + 5'h1;
          if (ck_fall && s.bits != '0)
          begin
            next_s.sr = {s.sr[22:0], 1'b0};
            next_s.pin.sdo = s.sr[22];
            next_s.falls = s.falls + 5'h1;
            if (s.falls == LAST_BIT)
            begin
              next_s.st = ST_CONV;
              next_s.start = 1'b1;
              next_s.pin.sdo = 1'b1;
            end
          end
        end
        else if (s.bits == LAST_BIT + 5'h1)
        begin
          // Last bit held through the 24th rise; data goes high one cycle later
          next_s.st = ST_CONV;
          next_s.start = 1'b1;
          next_s.pin.sdo = 1'b1;
        end
        else
        begin
          // Eight reference cycles per serial clock period
          next_s.div = s.div + 3'h1;
          if (s.div == DIV_RISE)
          begin
            next_s.pin.sck = 1'b1;
            next_s.bits = s.bits + 5'h1;
          end
          if (s.div == DIV_FALL)
          begin
            next_s.pin.sck = 1'b0;
            next_s.sr = {s.sr[22:0], 1'b0};
            next_s.pin.sdo = s.sr[22];
          end
        end
      end
      default:
        next_s.st = ST_POR;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
      s <= CORE_RST;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  sdo_hiz_a: assert property (s.cs2 |=> !o_pins.sdo_oe)
    else $error("data pin driven with chip select high");
  mode_pick_a: assert property ((cs_fall && s.st != ST_POR) |=> s.ext == !$past(s.ck2))
    else $error("wrong clock mode after chip select fall");
  conv_flag_a: assert property ((s.st == ST_CONV && !fifo_valid) |=> o_pins.sdo)
    else $error("done flag low during conversion");
  auto_sleep_a: assert property ((s.st == ST_CONV && fifo_valid && s.cs2) |=> s.st == ST_SLEEP)
    else $error("no sleep after finish with chip select high");
  ext_frozen_a: assert property ((s.st == ST_DATA && s.ext && s.bits == '0 && !cs_rise) |=> $stable(s.sr))
    else $error("result moved before first rise");
  ext_end_a: assert property ((s.st == ST_DATA && s.ext && !cs_rise && ck_fall && s.falls == LAST_BIT)
    |=> s.st == ST_CONV && o_conv_start && o_pins.sdo)
    else $error("no new conversion on last falling edge");
  abort_run_a: assert property ((s.st == ST_DATA && s.bits != '0 && cs_rise) |=> o_conv_start && s.st == ST_CONV)
    else $error("abort did not restart conversion");
  early_rise_a: assert property ((s.st == ST_WAIT && cs_rise) |=> s.st == ST_SLEEP && $stable(s.sr)
    && o_pins.sck_pull)
    else $error("status pulse did not return to sleep");
  test_delay_a: assert property ((s.st == ST_WAIT && s.tmr == '0 && !s.cs2) ##1 (!cs_rise) [*8]
    |-> s.st == ST_WAIT)
    else $error("readout began before status test delay");
  int_div_a: assert property ((s.st == ST_DATA && !s.ext && !cs_rise && s.div == DIV_RISE && s.bits != LAST_BIT)
    |=> o_pins.sck ##4 !o_pins.sck)
    else $error("internal clock not divided by eight");
  pull_off_a: assert property ((ck_fall && !(s.st == ST_WAIT && cs_rise)) |=> !o_pins.sck_pull)
    else $error("pull-up left on with pin low");
  load_fall_a: assert property ((s.st == ST_CONV && fifo_valid) |=> s.sr == {1'b0, $past(fifo_data)})
    else $error("result not loaded on done flag fall");

  ext_read_c: cover property (s.st == ST_DATA && s.ext ##1 s.st == ST_CONV);
  int_read_c: cover property (s.st == ST_DATA && !s.ext && s.bits == LAST_BIT ##[1:8] s.st == ST_CONV);
  abort_c: cover property (s.st == ST_DATA && s.bits != '0 && cs_rise);
  test_back_c: cover property (s.st == ST_WAIT && cs_rise);

endmodule

/* test/asr_host_model.sv */
// Host side model: drives chip select and the serial clock, samples data on rising clock edges
module asr_host_model
  import asr_pkg::*;
(
  // Clock
  input  wire logic      i_ref_clk,
  // Device pins
  input  wire asr_pins_t i_pins,
  output logic           o_cs_n,
  output logic           o_sck
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        drv;
  logic        val;
  logic [23:0] got;

  ////////////////////////////////////////////////////////////
  // Clock held low through power-on to ask for external mode
  initial
  begin
    o_cs_n = 1'b1;
    drv    = 1'b1;
    val    = 1'b0;
    got    = '0;
  end

  // Wire level: device drive, host drive, else the pull-up; a disabled pull leaves the pin low
  assign o_sck = i_pins.sck_oe ? i_pins.sck : (drv ? val : i_pins.sck_pull);

  ////////////////////////////////////////////////////////////
  // Pin tasks, all changes just after a falling reference edge
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic cs(input logic v);
    @(negedge i_ref_clk);
    o_cs_n = v;
    wait_cyc(8);
  endtask

  // Six cycles high and seven low so the synchroniser never loses an edge
  task automatic ext_clocks(input int n);
    got = '0;
    for (int k = 0; k < n; k++)
    begin
      @(negedge i_ref_clk);
      got = {got[22:0], i_pins.sdo};
      val = 1'b1;
      wait_cyc(6);
      val = 1'b0;
      wait_cyc(6);
    end
  endtask

  // Drive high, then let go so the pull-up keeps the pin high
  task automatic lift();
    val = 1'b1;
    wait_cyc(8);
    drv = 1'b0;
    wait_cyc(8);
  endtask

  // Follow the device clock; chip select is only raised once it is high again
  task automatic follow_internal();
    int n;
    got = '0;
    for (int k = 0; k < 24; k++)
    begin
      n = 0;
      while (o_sck !== 1'b0 && n < 4000)
      begin
        @(negedge i_ref_clk);
        n++;
      end
      while (o_sck !== 1'b1 && n < 4000)
      begin
        @(negedge i_ref_clk);
        n++;
      end
      got = {got[22:0], i_pins.sdo};
    end
  endtask
endmodule

/* test/asr_readout_tb.sv */
// Self-checking bench of the serial result readout
module asr_readout_tb
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int POR_SIM = 50;

  logic             i_ref_clk;
  logic             i_rstn;
  logic             i_res_valid;
  logic [RES_W-1:0] i_res_data;
  logic             o_res_ready;
  logic             o_conv_start;
  logic             cs_n;
  logic             sck;
  asr_pins_t        pins;
  int               miscompares;
  int               tests_run;
  int               starts;
  int               base;
  logic [RES_W-1:0] exp_q[$];

  asr_readout #(.P_POR_CYCLES(POR_SIM)) asr_readout_i (
    .i_ref_clk    (i_ref_clk),
    .i_rstn       (i_rstn),
    .i_cs_n       (cs_n),
    .i_sck        (sck),
    .o_pins       (pins),
    .i_res_valid  (i_res_valid),
    .i_res_data   (i_res_data),
    .o_res_ready  (o_res_ready),
    .o_conv_start (o_conv_start)
  );

  asr_host_model asr_host_model_i (
    .i_ref_clk (i_ref_clk),
    .i_pins    (pins),
    .o_cs_n    (cs_n),
    .o_sck     (sck)
  );

  ////////////////////////////////////////////////////////////
  // Clock and start pulse counter
  initial
  begin
    i_ref_clk = 1'b0;
    starts    = 0;
  end
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
    if (o_conv_start === 1'b1)
      starts <= starts + 1;

  // Frame on the wire: done flag low, then the result MSB first
  function automatic logic [23:0] frame(input logic [RES_W-1:0] w);
    return {1'b0, w};
  endfunction

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cut a hang short well past the expected run length
  initial
  begin
    #(1000000);
    miscompares++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(32'hc3118e5b));
    miscompares = 0;
    tests_run   = 0;
    i_rstn      = 1'b0;
    i_res_valid = 1'b0;
    i_res_data  = '0;
    repeat (12) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    repeat (POR_SIM + 10) @(negedge i_ref_clk);
    check("por start", 24'(starts), 24'h1);
    check("sdo idle", 24'(pins.sdo_oe), 24'h0);
    // Fill the buffer until it refuses
    while (o_res_ready === 1'b1 && exp_q.size() < 40)
    begin
      i_res_data  = RES_W'($urandom);
      i_res_valid = 1'b1;
      exp_q.push_back(i_res_data);
      @(negedge i_ref_clk);
    end
    i_res_valid = 1'b0;
    check("fill depth", 24'(exp_q.size() >= FIFO_D), 24'h1);
    // Drain by external clock readouts; one status test, one abort
    for (int n = 0; exp_q.size() > 0; n++)
    begin
      base = starts;
      asr_host_model_i.cs(1'b0);
      check("flag done", 24'({pins.sdo_oe, pins.sdo}), 24'h2);
      if (n == 0)
      begin
        asr_host_model_i.cs(1'b1);
        asr_host_model_i.cs(1'b0);
      end
      check("no restart", 24'(starts), 24'(base));
      asr_host_model_i.ext_clocks(n == 1 ? 5 : 24);
      if (n == 1)
      begin
        asr_host_model_i.cs(1'b1);
        check("abort start", 24'(starts), 24'(base + 1));
        check("abort bits", 24'(asr_host_model_i.got[4:0]), 24'(frame(exp_q[0]) >> 19));
      end
      else
      begin
        asr_host_model_i.wait_cyc(4);
        check("ext busy", 24'({pins.sdo_oe, pins.sdo}), (exp_q.size() > 1) ? 24'h2 : 24'h3);
        check("ext start", 24'(starts), 24'(base + 1));
        check("ext frame", asr_host_model_i.got, frame(exp_q[0]));
        asr_host_model_i.cs(1'b1);
      end
      void'(exp_q.pop_front());
    end
    asr_host_model_i.cs(1'b0);
    check("flag busy", 24'({pins.sdo_oe, pins.sdo}), 24'h3);
    asr_host_model_i.cs(1'b1);
    // One result finished while deselected, read with the internal clock
    i_res_data  = RES_W'($urandom);
    i_res_valid = 1'b1;
    exp_q.push_back(i_res_data);
    @(negedge i_ref_clk);
    i_res_valid = 1'b0;
    asr_host_model_i.lift();
    base = starts;
    asr_host_model_i.cs(1'b0);
    check("int clock low", 24'({pins.sck_oe, pins.sck}), 24'h2);
    asr_host_model_i.follow_internal();
    check("int frame", asr_host_model_i.got, frame(exp_q[0]));
    asr_host_model_i.wait_cyc(10);
    check("int end", 24'({pins.sck, pins.sdo}), 24'h3);
    check("int start", 24'(starts), 24'(base + 1));
    asr_host_model_i.cs(1'b1);
    // Second reset in mid-run: power-on count starts over and picks a mode again
    @(negedge i_ref_clk);
    i_rstn = 1'b0;
    repeat (12) @(negedge i_ref_clk);
    check("reset sdo", 24'(pins.sdo_oe), 24'h0);
    base = starts;
    i_rstn = 1'b1;
    repeat (POR_SIM + 10) @(negedge i_ref_clk);
    check("reset start", 24'(starts), 24'(base + 1));
    check("reset ready", 24'(o_res_ready), 24'h1);
    report_and_stop();
  end
endmodule
